// ==== core/tsmap_pkg.sv ====
// Shared constants for the timeslot map programming controller.
// Assumes a device whose slot maps take one 7-bit entry per write strobe.
`default_nettype none
package tsmap_pkg;
   // Slot map geometry.
   localparam int SLOT_CNT = 32;
   localparam int SLOT_W = 5;
   localparam int ENTRY_W = 7;
   localparam int SEL_W = 2;
   localparam int WORD_W = SEL_W + SLOT_W + ENTRY_W;
   // Entry field positions: type in bits 1:0, owner slot index in bits 6:2.
   localparam int TYPE_LSB = 0;
   localparam int OWNER_LSB = 2;
   // Slot type codes; bit 0 set means reference whatever bit 1 holds.
   localparam logic [1:0] TYPE_IDLE = 2'h0;
   localparam logic [1:0] TYPE_CONT = 2'h2;
   localparam logic [1:0] TYPE_REF = 2'h1;
   // Fixed slot positions.
   localparam logic [4:0] CELL_REF_SLOT = 5'h01;
   localparam logic [4:0] UNSTRUCT_REF_SLOT = 5'h00;
   localparam logic [4:0] E1_SIG_SLOT = 5'h10;
   localparam logic [4:0] GAPPED_LAST_CONT = 5'h17;
   // Map selectors on the device write port.
   localparam logic [1:0] MAP_RX = 2'h0;
   localparam logic [1:0] MAP_TX_A = 2'h1;
   localparam logic [1:0] MAP_TX_B = 2'h2;
   // Slots barred from structured channels, per framing.
   localparam logic [31:0] E1_BARRED = 32'h00010001;
   localparam logic [31:0] ALIGNED_BARRED = 32'h11111111;
   localparam logic [31:0] GAPPED_BARRED = 32'hff000000;
   // Idle cycles after each strobe so the device's ready drop can reach us.
   localparam logic [1:0] STROBE_GAP = 2'h3;
   // Reset values.
   localparam logic [4:0] SLOT_RST = 5'h00;
   localparam logic [1:0] SEL_RST = 2'h0;
   // Framing choices.
   typedef enum logic [1:0] {
      TSMAP_E1 = 2'h0,
      TSMAP_T1_ALIGNED = 2'h1,
      TSMAP_T1_GAPPED = 2'h2
   } tsmap_frm_e;
   // User commands.
   typedef enum logic [2:0] {
      TSMAP_OP_CELL = 3'h0,
      TSMAP_OP_UNSTRUCT = 3'h1,
      TSMAP_OP_CHAN_ADD = 3'h2,
      TSMAP_OP_CHAN_DEL = 3'h3,
      TSMAP_OP_CLEAR = 3'h4
   } tsmap_op_e;
   // Sequencer states, Gray coded along idle, walk, finish.
   typedef enum logic [1:0] {
      TSMAP_ST_IDLE = 2'h0,
      TSMAP_ST_WALK = 2'h1,
      TSMAP_ST_FINISH = 2'h3
   } tsmap_st_e;
endpackage
`default_nettype wire

// ==== core/tsmap_host_ctrl.sv ====
// Host-side controller that programs the receive and transmit slot maps of a
// framer-facing cell/circuit-emulation device over a strobed write port.
// Assumes the device ready pin is asynchronous and the user port is on clk_in.
`timescale 1ns/100ps
`default_nettype none
module tsmap_host_ctrl (
   // Clock, reset and enable.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic en_in,
   // User command port.
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire logic [2:0] cmd_op_in,
   input wire logic [1:0] cmd_framing_in,
   input wire logic [2:0] cmd_maps_in,
   input wire logic [31:0] cmd_slot_mask_in,
   output logic done_out,
   output logic err_out,
   output logic [4:0] chan_id_out,
   // Device slot map write port.
   output logic map_wr_out,
   input wire logic map_ready_in,
   output logic [1:0] map_sel_out,
   output logic [4:0] map_slot_out,
   output logic [6:0] map_entry_out
);
   tsmap_pkg::tsmap_st_e state_r;
   logic [2:0] op_r;
   logic [1:0] frm_r;
   logic [2:0] maps_r;
   logic [31:0] mask_r;
   logic [4:0] ref_r;
   logic [4:0] slot_r;
   logic [1:0] sel_r;
   logic rdy_meta_r;
   logic rdy_sync_r;
   logic [1:0] gap_r;
   logic [13:0] buf_mem_r [0:1];
   logic buf_wp_r;
   logic buf_rp_r;
   logic [1:0] buf_cnt_r;
   logic push;
   logic pop;
   logic buf_in_ready;
   logic want;
   logic step;
   logic cmd_take;
   logic cmd_bad;
   logic last_step;
   logic [4:0] lowest;

   // Lowest set bit of a slot mask; the channel reference and number.
   function automatic logic [4:0] lowest_slot(input logic [31:0] m);
      logic [4:0] r;
      r = 5'h1f;
      for (int i = 31; i >= 0; i--) begin
         if (m[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // Entry written for one slot under the command in hand.
   function automatic logic [6:0] slot_entry(input logic [2:0] op, input logic [1:0] frm,
                                             input logic [4:0] slot, input logic [4:0] rf);
      logic [1:0] t;
      logic [4:0] own;
      t = tsmap_pkg::TYPE_IDLE;
      own = tsmap_pkg::CELL_REF_SLOT;
      if (op == tsmap_pkg::TSMAP_OP_CELL) begin
         if (slot == tsmap_pkg::CELL_REF_SLOT) begin
            t = tsmap_pkg::TYPE_REF;
         end else if (frm == tsmap_pkg::TSMAP_E1) begin
            if (slot != 5'h00 && slot != tsmap_pkg::E1_SIG_SLOT) begin
               t = tsmap_pkg::TYPE_CONT;
            end
         end else if (frm == tsmap_pkg::TSMAP_T1_ALIGNED) begin
            if (slot[1:0] != 2'h0) begin
               t = tsmap_pkg::TYPE_CONT;
            end
         end else if (slot <= tsmap_pkg::GAPPED_LAST_CONT) begin
            t = tsmap_pkg::TYPE_CONT;
         end
      end else if (op == tsmap_pkg::TSMAP_OP_UNSTRUCT) begin
         own = tsmap_pkg::UNSTRUCT_REF_SLOT;
         if (slot == tsmap_pkg::UNSTRUCT_REF_SLOT) begin
            t = tsmap_pkg::TYPE_REF;
         end
      end else if (op == tsmap_pkg::TSMAP_OP_CHAN_ADD) begin
         own = rf;
         t = (slot == rf) ? tsmap_pkg::TYPE_REF : tsmap_pkg::TYPE_CONT;
      end
      return {own, t};
   endfunction

   // Slots barred from structured channels under the given framing.
   function automatic logic [31:0] barred(input logic [1:0] frm);
      unique case (frm)
         tsmap_pkg::TSMAP_E1: return tsmap_pkg::E1_BARRED;
         tsmap_pkg::TSMAP_T1_ALIGNED: return tsmap_pkg::ALIGNED_BARRED;
         tsmap_pkg::TSMAP_T1_GAPPED: return tsmap_pkg::GAPPED_BARRED;
         default: return 32'hffffffff;
      endcase
   endfunction

   // Command acceptance and validation.
   assign cmd_ready_out = (state_r == tsmap_pkg::TSMAP_ST_IDLE);
   assign cmd_take = en_in && cmd_valid_in && cmd_ready_out;
   assign lowest = lowest_slot(cmd_slot_mask_in);
   always_comb begin
      cmd_bad = (cmd_op_in > 3'(tsmap_pkg::TSMAP_OP_CLEAR)) || (cmd_framing_in == 2'h3);
      if (cmd_op_in == 3'(tsmap_pkg::TSMAP_OP_CHAN_ADD) ||
          cmd_op_in == 3'(tsmap_pkg::TSMAP_OP_CHAN_DEL)) begin
         // A channel may not be empty nor touch a barred slot.
         cmd_bad = cmd_bad || (cmd_slot_mask_in == 32'h0) ||
                   ((cmd_slot_mask_in & barred(cmd_framing_in)) != 32'h0);
      end
   end

   // Walk control: cell writes MAP_RX and MAP_TX_A, unstructured all three maps; others only selected maps, channels only masked slots.
   always_comb begin
      want = maps_r[sel_r] && (sel_r != 2'h3);
      if (op_r == 3'(tsmap_pkg::TSMAP_OP_CELL)) begin
         want = (sel_r == tsmap_pkg::MAP_RX) || (sel_r == tsmap_pkg::MAP_TX_A);
      end else if (op_r == 3'(tsmap_pkg::TSMAP_OP_UNSTRUCT)) begin
         want = (sel_r != 2'h3);
      end else if (op_r == 3'(tsmap_pkg::TSMAP_OP_CHAN_ADD) ||
                   op_r == 3'(tsmap_pkg::TSMAP_OP_CHAN_DEL)) begin
         want = want && mask_r[slot_r];
      end
   end
   assign push = (state_r == tsmap_pkg::TSMAP_ST_WALK) && want && buf_in_ready;
   assign step = (state_r == tsmap_pkg::TSMAP_ST_WALK) && (!want || buf_in_ready);
   assign last_step = (sel_r == tsmap_pkg::MAP_TX_B) && (slot_r == 5'h1f);

   // Sequencer and command capture.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_r <= tsmap_pkg::TSMAP_ST_IDLE;
         op_r <= 3'h0;
         frm_r <= 2'h0;
         maps_r <= 3'h0;
         mask_r <= 32'h0;
         ref_r <= tsmap_pkg::SLOT_RST;
      end else if (en_in) begin
         unique case (state_r)
            tsmap_pkg::TSMAP_ST_IDLE: begin
               if (cmd_take && !cmd_bad) begin
                  state_r <= tsmap_pkg::TSMAP_ST_WALK;
                  op_r <= cmd_op_in;
                  frm_r <= cmd_framing_in;
                  maps_r <= cmd_maps_in;
                  mask_r <= cmd_slot_mask_in;
                  ref_r <= lowest;
               end
            end
            tsmap_pkg::TSMAP_ST_WALK: begin
               if (step && last_step) begin
                  state_r <= tsmap_pkg::TSMAP_ST_FINISH;
               end
            end
            tsmap_pkg::TSMAP_ST_FINISH: begin
               // Report done only once every word has left for the device.
               if (buf_cnt_r == 2'h0 && gap_r == 2'h0) begin
                  state_r <= tsmap_pkg::TSMAP_ST_IDLE;
               end
            end
            default: state_r <= tsmap_pkg::TSMAP_ST_IDLE;
         endcase
      end
   end

   // Slot and map counters: slots run 0..31 within each map, maps 0..2.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         slot_r <= tsmap_pkg::SLOT_RST;
         sel_r <= tsmap_pkg::SEL_RST;
      end else if (en_in) begin
         if (cmd_take) begin
            slot_r <= tsmap_pkg::SLOT_RST;
            sel_r <= tsmap_pkg::SEL_RST;
         end else if (step) begin
            slot_r <= slot_r + 5'h01;
            if (slot_r == 5'h1f) begin
               sel_r <= sel_r + 2'h1;
            end
         end
      end
   end

   // Status pulses and channel number of the last accepted channel add; any other accepted command loads UNSTRUCT_REF_SLOT.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         done_out <= 1'b0;
         err_out <= 1'b0;
         chan_id_out <= tsmap_pkg::SLOT_RST;
      end else if (en_in) begin
         done_out <= (state_r == tsmap_pkg::TSMAP_ST_FINISH) && (buf_cnt_r == 2'h0) &&
                     (gap_r == 2'h0);
         err_out <= cmd_take && cmd_bad;
         if (cmd_take && !cmd_bad) begin
            chan_id_out <= (cmd_op_in == 3'(tsmap_pkg::TSMAP_OP_CHAN_ADD)) ?
                           lowest : tsmap_pkg::UNSTRUCT_REF_SLOT;
         end
      end
   end

   // Two-entry buffer; a stalled device fills it and then stalls the walk.
   assign buf_in_ready = (buf_cnt_r != 2'h2);
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         buf_wp_r <= 1'b0;
         buf_rp_r <= 1'b0;
         buf_cnt_r <= 2'h0;
      end else if (en_in) begin
         if (push) begin
            buf_mem_r[buf_wp_r] <= {sel_r, slot_r, slot_entry(op_r, frm_r, slot_r, ref_r)};
            buf_wp_r <= ~buf_wp_r;
         end
         if (pop) begin
            buf_rp_r <= ~buf_rp_r;
         end
         buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

   // Ready pin synchroniser; only the second stage is looked at.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdy_meta_r <= 1'b0;
         rdy_sync_r <= 1'b0;
      end else if (en_in) begin
         rdy_meta_r <= map_ready_in;
         rdy_sync_r <= rdy_meta_r;
      end
   end

   // Pin driver: one-cycle strobe, then a gap that covers the sync delay so a
   // device that drops ready right after a strobe is never overrun.
   assign pop = (buf_cnt_r != 2'h0) && rdy_sync_r && (gap_r == 2'h0);
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         map_wr_out <= 1'b0;
         map_sel_out <= tsmap_pkg::SEL_RST;
         map_slot_out <= tsmap_pkg::SLOT_RST;
         map_entry_out <= 7'h00;
         gap_r <= 2'h0;
      end else if (en_in) begin
         map_wr_out <= pop;
         if (pop) begin
            {map_sel_out, map_slot_out, map_entry_out} <= buf_mem_r[buf_rp_r];
            gap_r <= tsmap_pkg::STROBE_GAP;
         end else if (gap_r != 2'h0) begin
            gap_r <= gap_r - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/tsmap_host_ctrl_chk.sv ====
// Port-level checks for the slot map programming controller.
// Assumes it is bound into tsmap_host_ctrl and that en_in stays high.
`timescale 1ns/100ps
`default_nettype none
module tsmap_host_ctrl_chk (
   // Clock, reset and enable.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic en_in,
   // User command port.
   input wire logic cmd_valid_in,
   input wire logic cmd_ready_out,
   input wire logic done_out,
   input wire logic err_out,
   // Device write port.
   input wire logic map_wr_out,
   input wire logic [4:0] map_slot_out,
   input wire logic [6:0] map_entry_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   logic take;
   // A command is taken on the edge where valid meets ready.
   assign take = en_in && cmd_valid_in && cmd_ready_out;
   chk_type_code_legal: assert property (map_wr_out |-> map_entry_out[1:0] != 2'h3)
      else $error("slot entry carries an unused type code");
   chk_ref_owns_self: assert property (map_wr_out && map_entry_out[0]
      |-> map_entry_out[6:2] == map_slot_out) else $error("reference entry names another slot");
   chk_strobe_gap_held: assert property (map_wr_out |=> !map_wr_out [*3])
      else $error("write strobes closer than four cycles");
   chk_busy_after_take: assert property (take |=> !cmd_ready_out || err_out)
      else $error("controller still ready after taking a command");
   chk_done_single_pulse: assert property (done_out |=> !done_out && !err_out)
      else $error("done is longer than one cycle");
   chk_err_from_take: assert property (err_out |-> $past(take) && cmd_ready_out)
      else $error("error pulse without a refused command");
   chk_wr_only_busy: assert property (map_wr_out |-> !cmd_ready_out)
      else $error("map written while idle");
   chk_walk_bounded: assert property (take ##1 !err_out |-> ##[90:1000] done_out)
      else $error("command walk not finished in time");
endmodule
`default_nettype wire

// ==== verification/tsmap_dev_model.sv ====
// Behavioural stand-in for the device's three slot map memories.
// Assumes one word per strobe; slow_in makes it drop ready after each word.
`timescale 1ns/100ps
`default_nettype none
module tsmap_dev_model (
   // Clock, reset and pacing.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic slow_in,
   // Slot map write port.
   input wire logic map_wr_in,
   output logic map_ready_out,
   input wire logic [1:0] map_sel_in,
   input wire logic [4:0] map_slot_in,
   input wire logic [6:0] map_entry_in
);
   logic [6:0] mem [0:2][0:31];
   int wr_cnt;
   int bad_cnt;
   logic [2:0] hold_r;
   // Unwritten entries read 7f, so a lost or misdirected word stands out.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         for (int m = 0; m < 3; m++) begin
            for (int s = 0; s < 32; s++) begin
               mem[m][s] <= 7'h7f;
            end
         end
         wr_cnt <= 0;
         bad_cnt <= 0;
      end else if (map_wr_in) begin
         mem[map_sel_in][map_slot_in] <= map_entry_in;
         wr_cnt <= wr_cnt + 1;
         if (!map_ready_out || map_sel_in == 2'h3) begin
            bad_cnt <= bad_cnt + 1;
         end
      end
   end
   // A slow device holds ready low for seven cycles after each word.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         hold_r <= 3'h0;
      end else if (map_wr_in && slow_in) begin
         hold_r <= 3'h7;
      end else if (hold_r != 3'h0) begin
         hold_r <= hold_r - 3'h1;
      end
   end
   assign map_ready_out = (hold_r == 3'h0);
endmodule
`default_nettype wire

// ==== verification/tsmap_host_ctrl_bench.sv ====
// Self-checking bench for the slot map controller against a device model.
// Assumes the checker and device model files are compiled first.
`timescale 1ns/100ps
`default_nettype none
bind tsmap_host_ctrl tsmap_host_ctrl_chk chk_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .en_in(en_in), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
   .done_out(done_out), .err_out(err_out), .map_wr_out(map_wr_out),
   .map_slot_out(map_slot_out), .map_entry_out(map_entry_out));
module tsmap_host_ctrl_bench;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic cmd_valid = 1'b0;
   logic [2:0] cmd_op = 3'h0;
   logic [1:0] cmd_fr = 2'h0;
   logic [2:0] cmd_maps = 3'h0;
   logic [31:0] cmd_mask = 32'h0;
   logic slow = 1'b0;
   logic cmd_ready, done, err, map_wr, map_ready;
   logic [4:0] chan_id, map_slot;
   logic [1:0] map_sel;
   logic [6:0] map_entry;
   int error_cnt = 0;
   int n_checks = 0;
   int cycles = 0;
   tsmap_host_ctrl dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .en_in(1'b1),
      .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op),
      .cmd_framing_in(cmd_fr), .cmd_maps_in(cmd_maps), .cmd_slot_mask_in(cmd_mask),
      .done_out(done), .err_out(err), .chan_id_out(chan_id), .map_wr_out(map_wr),
      .map_ready_in(map_ready), .map_sel_out(map_sel), .map_slot_out(map_slot),
      .map_entry_out(map_entry));
   tsmap_dev_model dev (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .slow_in(slow),
      .map_wr_in(map_wr), .map_ready_out(map_ready), .map_sel_in(map_sel),
      .map_slot_in(map_slot), .map_entry_in(map_entry));
   always #20 clk_in = ~clk_in;
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // The whole run needs a few thousand cycles; far beyond that means a hang.
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Offers one command, then waits for its done or error pulse.
   task automatic run(input logic [2:0] op, input logic [1:0] fr, input logic [2:0] mp,
      input logic [31:0] mk, input logic exp_err);
      int n;
      n = 0;
      @(posedge clk_in);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_fr <= fr;
      cmd_maps <= mp;
      cmd_mask <= mk;
      @(posedge clk_in);
      cmd_valid <= 1'b0;
      @(posedge clk_in);
      while (done !== 1'b1 && err !== 1'b1 && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      chk({err, done}, {exp_err, !exp_err});
   endtask
   // Expected cell-mode slot type for a framing and map position.
   function automatic logic [1:0] cell_type(input logic [1:0] fr, input int s);
      if (s == 1) return 2'h1;
      if ((fr == 2'h0 && (s == 0 || s == 16)) || (fr == 2'h1 && s % 4 == 0) ||
         (fr == 2'h2 && s >= 24)) return 2'h0;
      return 2'h2;
   endfunction
   task automatic t_refuse();
      int w;
      w = dev.wr_cnt;
      run(3'h0, 2'h3, 3'h7, 32'h0, 1'b1);
      run(3'h2, 2'h0, 3'h7, 32'h00010000, 1'b1);
      run(3'h2, 2'h1, 3'h7, 32'h00000110, 1'b1);
      run(3'h2, 2'h2, 3'h7, 32'h01000002, 1'b1);
      run(3'h3, 2'h0, 3'h7, 32'h0, 1'b1);
      run(3'h5, 2'h0, 3'h7, 32'h00000002, 1'b1);
      chk(dev.wr_cnt - w, 0);
   endtask
   task automatic t_cell(input logic [1:0] fr, input logic sl);
      int w;
      w = dev.wr_cnt;
      slow <= sl;
      run(3'h0, fr, 3'h0, 32'h0, 1'b0);
      slow <= 1'b0;
      chk(dev.wr_cnt - w, 64);
      chk(dev.mem[2][1], 7'h7f);
      for (int m = 0; m < 2; m++) begin
         for (int s = 0; s < 32; s++) begin
            chk(dev.mem[m][s], {5'h01, cell_type(fr, s)});
         end
      end
   endtask
   task automatic t_unstruct();
      int w;
      w = dev.wr_cnt;
      run(3'h1, 2'h0, 3'h7, 32'h0, 1'b0);
      chk(dev.wr_cnt - w, 96);
      for (int m = 0; m < 3; m++) begin
         chk(dev.mem[m][0], 7'h01);
         for (int s = 1; s < 32; s++) begin
            chk(dev.mem[m][s][1:0], 2'h0);
         end
      end
   endtask
   task automatic t_channels();
      int w;
      w = dev.wr_cnt;
      run(3'h4, 2'h0, 3'h7, 32'h0, 1'b0);
      run(3'h2, 2'h0, 3'h5, 32'h00100088, 1'b0);
      chk(chan_id, 5'h03);
      chk(dev.mem[2][3], 7'h0d);
      chk(dev.mem[0][20], 7'h0e);
      chk(dev.mem[1][3][1:0], 2'h0);
      run(3'h2, 2'h0, 3'h5, 32'h00000220, 1'b0);
      chk(chan_id, 5'h05);
      run(3'h3, 2'h0, 3'h5, 32'h00100088, 1'b0);
      chk(dev.wr_cnt - w, 112);
      for (int m = 0; m < 3; m += 2) begin
         chk(dev.mem[m][5], 7'h15);
         chk(dev.mem[m][9], 7'h16);
         chk(dev.mem[m][7][1:0], 2'h0);
      end
      // T1 framings accept slots outside their barred sets, gapped even slot 0.
      run(3'h2, 2'h1, 3'h2, 32'h00000006, 1'b0);
      chk(chan_id, 5'h01);
      chk(dev.mem[1][2], 7'h06);
      run(3'h2, 2'h2, 3'h1, 32'h00800001, 1'b0);
      chk(chan_id, 5'h00);
      chk(dev.mem[0][0], 7'h01);
      chk(dev.mem[0][23], 7'h02);
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      t_refuse();
      t_cell(2'h0, 1'b1);
      t_cell(2'h1, 1'b0);
      t_cell(2'h2, 1'b0);
      t_unstruct();
      t_channels();
      chk(dev.bad_cnt, 0);
      test_done();
   end
endmodule
`default_nettype wire
